// [include/uak_pkg.sv]
package uak_pkg;
  // ==========================================================
  // Register offsets on the 6-bit parallel port
  localparam logic [5:0] ADDR_INTERVAL_B3 = 6'h16; // Most significant byte
  localparam logic [5:0] ADDR_INTERVAL_B2 = 6'h17;
  localparam logic [5:0] ADDR_INTERVAL_B1 = 6'h18;
  localparam logic [5:0] ADDR_INTERVAL_B0 = 6'h19; // Least significant byte
  localparam logic [5:0] ADDR_POWER_CTL = 6'h1d;
  localparam logic [5:0] ADDR_UPDATE_CTL = 6'h1f;
  localparam logic [5:0] ADDR_PATH_CTL = 6'h20;
  localparam logic [5:0] ADDR_AMP_HI = 6'h21;
  localparam logic [5:0] ADDR_AMP_LO = 6'h22;
  localparam logic [5:0] ADDR_RAMP_RATE = 6'h25;
  localparam logic [5:0] ADDR_AUX_HI = 6'h26;
  localparam logic [5:0] ADDR_AUX_LO = 6'h27;
  // ==========================================================
  // Field positions
  localparam int BIT_AUX_PD = 1;
  localparam int BIT_MAIN_PD = 2;
  localparam int BIT_INT_UPDATE = 0;
  localparam int BIT_SHAPE_INT = 4;
  localparam int BIT_SHAPE_EN = 5;
  localparam int BIT_SINC_BYPASS = 6;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_INTERVAL = 32'h0000_0000;
  localparam logic [7:0] RST_POWER_CTL = 8'h00;
  localparam logic [7:0] RST_UPDATE_CTL = 8'h01; // Internal update source
  localparam logic [7:0] RST_PATH_CTL = 8'h00; // Inverse sinc engaged
  localparam logic [11:0] RST_AMP = 12'h000;
  localparam logic [7:0] RST_RAMP_RATE = 8'h00;
  localparam logic [11:0] RST_AUX = 12'h000;
  // ==========================================================
  // Timing counts and amplitude limits
  localparam logic [3:0] STROBE_HIGH_CYCLES = 4'h8;
  localparam logic [31:0] MIN_MARKED_INTERVAL = 32'h0000_0005;
  localparam logic [7:0] MIN_RAMP_RATE = 8'h03;
  localparam logic [11:0] AMP_FULL = 12'hfff;
  localparam logic [11:0] AMP_ZERO = 12'h000;
endpackage : uak_pkg

// [logic/uak_update_keying.sv]
`timescale 1ns/1ps
module uak_update_keying #(
  parameter int SAMPLE_W = 12 // Width of the synthesized sample
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [5:0] portAddr, // Register byte address
  input wire logic [7:0] portWrData, // Write data byte
  input wire logic portWrite, // Write strobe, one cycle
  output logic [7:0] portRdData, // Read data, one cycle after address
  input wire logic updateStrobeIn, // Strobe pin level seen at the pad
  output logic updateStrobeOut, // Strobe pin driven level
  output logic updateStrobeOe, // Strobe pin enable, high while driving
  input wire logic amplitudeKeying, // Keying pin
  input wire logic signed [SAMPLE_W-1:0] sampleIn, // Synthesized sample
  output logic signed [SAMPLE_W-1:0] mainDacData, // Main DAC input word
  output logic [11:0] auxDacData, // Aux DAC twos complement word
  output logic mainDacPowerdown, // Main DAC powered down
  output logic auxDacPowerdown, // Aux DAC powered down
  output logic inverseSincEnable, // Inverse sinc filter in path
  output logic updatePulse // One-cycle transfer pulse
);
  import uak_pkg::*;

  // ==========================================================
  // Buffered (host side) registers
  logic [31:0] bufInterval;
  logic [7:0] bufPower;
  logic [7:0] bufUpdCtl;
  logic [7:0] bufPath;
  logic [11:0] bufAmp;
  logic [7:0] bufRate;
  logic [11:0] bufAux;

  // Write hit decode, shared by every buffer byte
  function automatic logic hit(input logic [5:0] a);
    hit = portWrite && (portAddr == a);
  endfunction : hit

  // ==========================================================
  // Named write hits, one per buffer byte
  // A write outside the map matches no wire and is dropped
  wire hitIntB3 = hit(ADDR_INTERVAL_B3);
  wire hitIntB2 = hit(ADDR_INTERVAL_B2);
  wire hitIntB1 = hit(ADDR_INTERVAL_B1);
  wire hitIntB0 = hit(ADDR_INTERVAL_B0);
  wire hitPower = hit(ADDR_POWER_CTL);
  wire hitUpdCtl = hit(ADDR_UPDATE_CTL);
  wire hitPath = hit(ADDR_PATH_CTL);
  wire hitAmpHi = hit(ADDR_AMP_HI);
  wire hitAmpLo = hit(ADDR_AMP_LO);
  wire hitRate = hit(ADDR_RAMP_RATE);
  wire hitAuxHi = hit(ADDR_AUX_HI);
  wire hitAuxLo = hit(ADDR_AUX_LO);

  // Host writes land in the buffer only
  // The active core never sees a half-written word: it copies the
  // buffer as a whole, bar the update control byte, and only on an update edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bufInterval <= RST_INTERVAL;
      bufPower <= RST_POWER_CTL;
      bufUpdCtl <= RST_UPDATE_CTL;
      bufPath <= RST_PATH_CTL;
      bufAmp <= RST_AMP;
      bufRate <= RST_RAMP_RATE;
      bufAux <= RST_AUX;
    end else begin
      if (hitIntB3) bufInterval[31:24] <= portWrData;
      if (hitIntB2) bufInterval[23:16] <= portWrData;
      if (hitIntB1) bufInterval[15:8] <= portWrData;
      if (hitIntB0) bufInterval[7:0] <= portWrData;
      if (hitPower) bufPower <= portWrData;
      if (hitUpdCtl) bufUpdCtl <= portWrData;
      if (hitPath) bufPath <= portWrData;
      if (hitAmpHi) bufAmp[11:8] <= portWrData[3:0];
      if (hitAmpLo) bufAmp[7:0] <= portWrData;
      if (hitRate) bufRate <= portWrData;
      if (hitAuxHi) bufAux[11:8] <= portWrData[3:0];
      if (hitAuxLo) bufAux[7:0] <= portWrData;
    end
  end

  // Readback of the buffer, unmapped reads give zero
  // Reads show what was written, not what the core is using, so a
  // host can check its writes before it issues an update
  logic [7:0] next_portRdData;
  always_comb begin
    unique case (portAddr)
      ADDR_INTERVAL_B3: next_portRdData = bufInterval[31:24];
      ADDR_INTERVAL_B2: next_portRdData = bufInterval[23:16];
      ADDR_INTERVAL_B1: next_portRdData = bufInterval[15:8];
      ADDR_INTERVAL_B0: next_portRdData = bufInterval[7:0];
      ADDR_POWER_CTL: next_portRdData = bufPower;
      ADDR_UPDATE_CTL: next_portRdData = bufUpdCtl;
      ADDR_PATH_CTL: next_portRdData = bufPath;
      ADDR_AMP_HI: next_portRdData = {4'h0, bufAmp[11:8]};
      ADDR_AMP_LO: next_portRdData = bufAmp[7:0];
      ADDR_RAMP_RATE: next_portRdData = bufRate;
      ADDR_AUX_HI: next_portRdData = {4'h0, bufAux[11:8]};
      ADDR_AUX_LO: next_portRdData = bufAux[7:0];
      default: next_portRdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) portRdData <= 8'h00;
    else portRdData <= next_portRdData;
  end

  // ==========================================================
  // External strobe synchroniser and filter
  // The pad is asynchronous; a level counts only once the second and
  // third stages agree, so a runt glitch cannot make a false update
  logic [2:0] strobeSync;
  logic strobeStable;
  logic strobeStablePrev;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobeSync <= 3'h0;
      strobeStable <= 1'b0;
      strobeStablePrev <= 1'b0;
    end else begin
      strobeSync <= {strobeSync[1:0], updateStrobeIn};
      if (strobeSync[1] == strobeSync[2]) strobeStable <= strobeSync[2];
      strobeStablePrev <= strobeStable;
    end
  end

  // ==========================================================
  // Internal update counter at half the clock rate
  wire internalMode = bufUpdCtl[BIT_INT_UPDATE];
  logic halfTick;
  logic [31:0] updCount;
  logic [31:0] activeInterval;
  wire internalFire = internalMode && halfTick && (updCount == 32'h0);
  wire externalFire = !internalMode && strobeStable && !strobeStablePrev;
  wire doUpdate = internalFire || externalFire;

  // Next count: parked on the active interval in external mode, so a
  // return to internal mode starts a whole interval. It moves only on
  // the half-rate tick, which gives the (N+1)*2 clock spacing.
  wire updAtZero = (updCount == 32'h0);
  wire [31:0] updCountDown = updCount - 32'h1;
  wire [31:0] next_updCount = !internalMode ? activeInterval :
    !halfTick ? updCount :
    updAtZero ? activeInterval : updCountDown;

  // Half-rate tick and update down-counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halfTick <= 1'b0;
      updCount <= RST_INTERVAL;
    end else begin
      halfTick <= !halfTick;
      updCount <= next_updCount;
    end
  end

  // ==========================================================
  // Active core registers, loaded only on an update
  // Every field moves in the same clock, so the core always sees one
  // consistent set of settings
  logic [7:0] activePower;
  logic [7:0] activePath;
  logic [11:0] activeAmp;
  logic [7:0] activeRate;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeInterval <= RST_INTERVAL;
      activePower <= RST_POWER_CTL;
      activePath <= RST_PATH_CTL;
      activeAmp <= RST_AMP;
      activeRate <= RST_RAMP_RATE;
      auxDacData <= RST_AUX;
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= doUpdate;
      if (doUpdate) begin
        activeInterval <= bufInterval;
        activePower <= bufPower;
        activePath <= bufPath;
        activeAmp <= bufAmp;
        activeRate <= bufRate;
        auxDacData <= bufAux;
      end
    end
  end

  // ==========================================================
  // Strobe pin drive in internal mode
  logic [3:0] highLeft;
  wire pinStuckHigh = activeInterval < MIN_MARKED_INTERVAL;
  // High-time counter: loaded on each fire, runs down to zero.
  // Short intervals would overlap the pulses, so the pin stays high.
  wire [3:0] next_highLeft = internalFire ? STROBE_HIGH_CYCLES :
    (highLeft != 4'h0) ? highLeft - 4'h1 : 4'h0;
  wire highHeld = highLeft > 4'h1;
  wire next_updateStrobeOut = internalMode &&
    (internalFire || highHeld || pinStuckHigh);

  // Registered pin level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      highLeft <= 4'h0;
      updateStrobeOut <= 1'b0;
    end else begin
      highLeft <= next_highLeft;
      updateStrobeOut <= next_updateStrobeOut;
    end
  end
  // Pin is driven only in internal mode, an input otherwise
  assign updateStrobeOe = internalMode;

  // ==========================================================
  // Keying pin synchroniser and filter
  // Same three-stage scheme as the strobe pad, for the same reason
  logic [2:0] keySync;
  logic keyStable;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      keySync <= 3'h0;
      keyStable <= 1'b0;
    end else begin
      keySync <= {keySync[1:0], amplitudeKeying};
      if (keySync[1] == keySync[2]) keyStable <= keySync[2];
    end
  end

  // ==========================================================
  // Ramp-rate counter and amplitude counter
  logic [7:0] rateCount;
  logic [11:0] rampAmp;
  wire rampStall = activeRate < MIN_RAMP_RATE;
  wire rateAtZero = (rateCount == 8'h00);
  wire rampPulse = !rampStall && rateAtZero;
  // Rate counter reloads at zero, giving one pulse each N+1 clocks
  wire [7:0] next_rateCount = rampStall ? rateCount :
    rateAtZero ? activeRate : rateCount - 8'h01;
  // Amplitude steps toward the keyed end and saturates there; the top
  // is the multiplier full-scale code, not a programmed peak
  wire rampUp = keyStable && (rampAmp != AMP_FULL);
  wire rampDown = !keyStable && (rampAmp != AMP_ZERO);
  wire [11:0] next_rampAmp = !rampPulse ? rampAmp :
    rampUp ? rampAmp + 12'h001 :
    rampDown ? rampAmp - 12'h001 : rampAmp;

  // Ramp state registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rateCount <= RST_RAMP_RATE;
      rampAmp <= AMP_ZERO;
    end else begin
      rateCount <= next_rateCount;
      rampAmp <= next_rampAmp;
    end
  end

  // ==========================================================
  // Amplitude multiplier and DAC path controls
  // The code is taken as unsigned, so all ones gives 4095/4096 of the
  // sample; bits below the binary point are simply dropped
  wire shapeEnable = activePath[BIT_SHAPE_EN];
  wire [11:0] scaleCode = activePath[BIT_SHAPE_INT] ? rampAmp
                                                    : activeAmp;
  wire signed [SAMPLE_W+12:0] scaled = sampleIn * $signed({1'b0, scaleCode});
  wire signed [SAMPLE_W-1:0] scaledTrunc = scaled[SAMPLE_W+11:12];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) mainDacData <= '0;
    else mainDacData <= shapeEnable ? scaledTrunc : sampleIn;
  end

  // Power-down and filter controls follow the active registers
  assign mainDacPowerdown = activePower[BIT_MAIN_PD];
  assign auxDacPowerdown = activePower[BIT_AUX_PD];
  assign inverseSincEnable = !activePath[BIT_SINC_BYPASS];
endmodule : uak_update_keying

// [verification/uak_checker.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker
module uak_checker (
  input wire logic clk, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic updateStrobeIn, // Pad level
  input wire logic updateStrobeOut, // Pad drive level
  input wire logic updateStrobeOe, // Pad enable
  input wire logic updatePulse, // Transfer pulse
  input wire logic [11:0] auxDacData, // Aux word
  input wire logic mainDacPowerdown, // Main DAC off
  input wire logic inverseSincEnable // Sinc in path
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Strobe, transfer and reset relations
  a_strobe_high_time: assert property (
    $rose(updateStrobeOut) |-> (updateStrobeOut || !updateStrobeOe) [*8])
    else $error("strobe high time short");
  a_pulse_single: assert property (
    updatePulse |=> !updatePulse) else $error("pulse too long");
  a_reset_internal: assert property (
    $rose(reset_n) |-> updateStrobeOe) else $error("not internal");
  a_reset_path: assert property (
    $rose(reset_n) |-> inverseSincEnable && !mainDacPowerdown)
    else $error("path reset wrong");
  a_aux_on_update: assert property (
    $changed(auxDacData) |-> ##[0:2] updatePulse)
    else $error("aux moved without update");
  a_pd_on_update: assert property (
    $changed(mainDacPowerdown) |-> ##[0:2] updatePulse)
    else $error("power moved without update");
  a_ext_quiet: assert property (
    (!updateStrobeOe && !updateStrobeIn) [*8] |-> !updatePulse)
    else $error("update without strobe");
  a_ext_latency: assert property (
    !updateStrobeOe && $rose(updateStrobeIn) |-> ##[2:8] updatePulse)
    else $error("external update late");
endmodule : uak_checker
bind uak_update_keying uak_checker chk (.clk(clk), .reset_n(reset_n),
  .updateStrobeIn(updateStrobeIn), .updateStrobeOut(updateStrobeOut),
  .updateStrobeOe(updateStrobeOe), .updatePulse(updatePulse),
  .auxDacData(auxDacData), .mainDacPowerdown(mainDacPowerdown),
  .inverseSincEnable(inverseSincEnable));

// [verification/uak_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Host side: strobe pad driver and keying pin
module uak_host_model (
  input wire logic clk, // System clock
  input wire logic pulseCmd, // Request one strobe pulse
  input wire logic keyCmd, // Wanted keying level
  input wire logic strobeOe, // Device drives pad
  input wire logic strobeOut, // Device pad level
  output logic strobePad, // Resolved pad level
  output logic keyPin // Keying pin
);
  logic [3:0] hostCount = 4'h0;
  // Pulse held ten clocks so the synchroniser sees it
  always @(posedge clk) begin
    if (pulseCmd) hostCount <= #1 4'ha;
    else if (hostCount != 4'h0) hostCount <= #1 hostCount - 4'h1;
  end
  // Pad resolved from both drivers
  assign strobePad = strobeOe ? strobeOut : (hostCount != 4'h0);
  assign keyPin = keyCmd;
endmodule : uak_host_model

// [verification/uak_update_keying_test.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench top
module uak_update_keying_test;
  import uak_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] portAddr = 6'h00;
  logic [7:0] portWrData = 8'h00;
  logic portWrite = 1'b0;
  logic pulseCmd = 1'b0;
  logic keyCmd = 1'b0;
  logic signed [11:0] sampleIn = 12'sh7ff;
  logic signed [11:0] mainDacData;
  logic [11:0] auxDacData;
  logic [7:0] portRdData, rdVal;
  logic pad, strobeOut, strobeOe, keyPin, updatePulse, mainPd, auxPd, sincOn;
  int badCount = 0;
  int checked = 0;
  int n;
  uak_update_keying dut (.clk(clk), .reset_n(reset_n), .portAddr(portAddr),
    .portWrData(portWrData), .portWrite(portWrite), .portRdData(portRdData),
    .updateStrobeIn(pad), .updateStrobeOut(strobeOut),
    .updateStrobeOe(strobeOe), .amplitudeKeying(keyPin),
    .sampleIn(sampleIn), .mainDacData(mainDacData), .auxDacData(auxDacData),
    .mainDacPowerdown(mainPd), .auxDacPowerdown(auxPd),
    .inverseSincEnable(sincOn), .updatePulse(updatePulse));
  uak_host_model host (.clk(clk), .pulseCmd(pulseCmd), .keyCmd(keyCmd),
    .strobeOe(strobeOe), .strobeOut(strobeOut), .strobePad(pad),
    .keyPin(keyPin));
  // Clock and watchdog
  initial forever #2 clk = ~clk;
  initial begin
    #200000;
    badCount++;
    reportAndStop;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    portAddr = a;
    portWrData = d;
    portWrite = 1'b1;
    tick(1);
    portWrite = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    portAddr = a;
    tick(1);
    rdVal = portRdData;
  endtask : rd
  task automatic waitPulse;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (updatePulse !== 1'b1 && n < 3000);
    check("update seen", n < 3000, 1'b1);
  endtask : waitPulse
  task automatic hostPulse;
    pulseCmd = 1'b1;
    tick(1);
    pulseCmd = 1'b0;
    waitPulse;
  endtask : hostPulse
  // ==========================================================
  // Scenarios
  task automatic testReset;
    rd(ADDR_UPDATE_CTL);
    check("update ctl", rdVal, RST_UPDATE_CTL);
    rd(6'h3f);
    check("unmapped", rdVal, 8'h00);
    check("pin enable", strobeOe, 1'b1);
    check("sinc on", sincOn, 1'b1);
    $display("reset test done");
  endtask : testReset
  task automatic testInternal;
    for (int i = 0; i < 3; i++) wr(ADDR_INTERVAL_B3 + 6'(i), 8'h00);
    wr(ADDR_INTERVAL_B0, 8'h05);
    wr(ADDR_POWER_CTL, 8'h06);
    wr(ADDR_PATH_CTL, 8'h40);
    waitPulse;
    waitPulse;
    check("main pd", mainPd, 1'b1);
    check("aux pd", auxPd, 1'b1);
    check("sinc bypass", sincOn, 1'b0);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (updatePulse !== 1'b1 && n < 100);
    check("period", n, 32'd12);
    n = 0;
    while (strobeOut === 1'b1 && n < 100) begin
      n++;
      tick(1);
    end
    check("strobe high", n, 32'd8);
    wr(ADDR_INTERVAL_B0, 8'h02);
    waitPulse;
    waitPulse;
    n = 0;
    repeat (40) begin
      tick(1);
      if (strobeOut !== 1'b1) n++;
    end
    check("strobe lows", n, 32'd0);
    $display("internal test done");
  endtask : testInternal
  task automatic testExternal;
    wr(ADDR_UPDATE_CTL, 8'h00);
    check("pin enable", strobeOe, 1'b0);
    wr(ADDR_AUX_HI, 8'h1a);
    wr(ADDR_AUX_LO, 8'h5c);
    wr(ADDR_POWER_CTL, 8'h00);
    wr(ADDR_PATH_CTL, 8'h00);
    tick(20);
    check("aux held", auxDacData, RST_AUX);
    hostPulse;
    check("aux word", auxDacData, 12'ha5c);
    check("main pd", mainPd, 1'b0);
    rd(ADDR_AUX_HI);
    check("aux hi", rdVal, 8'h0a);
    $display("external test done");
  endtask : testExternal
  task automatic testShaping;
    check("bypass", mainDacData, 12'h7ff);
    wr(ADDR_PATH_CTL, 8'h20);
    wr(ADDR_AMP_HI, 8'h08);
    wr(ADDR_AMP_LO, 8'h00);
    hostPulse;
    tick(3);
    check("manual", mainDacData, 12'h3ff);
    wr(ADDR_PATH_CTL, 8'h30);
    wr(ADDR_RAMP_RATE, MIN_RAMP_RATE);
    keyCmd = 1'b1;
    hostPulse;
    tick(17000);
    check("ramp top", mainDacData, 12'h7fe);
    keyCmd = 1'b0;
    tick(17000);
    check("ramp zero", mainDacData, 12'h000);
    wr(ADDR_RAMP_RATE, 8'h02);
    hostPulse;
    keyCmd = 1'b1;
    tick(200);
    check("stalled", mainDacData, 12'h000);
    $display("shaping test done");
  endtask : testShaping
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : reportAndStop
  // Main sequence
  initial begin
    tick(10);
    reset_n = 1'b1;
    testReset;
    testInternal;
    testExternal;
    testShaping;
    reportAndStop;
  end
endmodule : uak_update_keying_test
